// File: wdd_decoder.sv
// Instruction decoder and register set of a dual 64-tap potentiometer.
// Assumes scl, sda and all straps come from outside and are resynchronised here.
`timescale 1ns/1ns
module wdd_decoder #(
   parameter logic [16:0] PROG_CYCLES = 17'(wdd_pkg::PROG_CYCLES)
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        addr_strap_3,
   input  wire logic        addr_strap_2,
   input  wire logic        addr_strap_1,
   input  wire logic        addr_strap_0,
   input  wire logic        write_guard_n,
   output logic [5:0]       wiper_pos0,
   output logic [5:0]       wiper_pos1,
   output logic [63:0]      tap_sel0,
   output logic [63:0]      tap_sel1,
   output logic             busy
);
   typedef enum logic [2:0] {
      IDLE, ADDR, INSTR, RX_WIPER, RX_STORED, TX, STEP, WAIT_STOP
   } wdd_state_type;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [6:0] meta_q;
   logic [6:0] sync_q;
   logic       scl_prev_q;
   logic       sda_prev_q;
   logic       scl_s;
   logic       sda_s;
   logic [3:0] strap_s;
   logic       guard_n_s;
   logic       start;
   logic       stop;
   logic       scl_rise;
   logic       scl_fall;

   always_ff @(posedge clock) begin
      meta_q     <= {write_guard_n, addr_strap_3, addr_strap_2, addr_strap_1,
                     addr_strap_0, sda_in, scl};
      sync_q     <= meta_q;
      scl_prev_q <= sync_q[0];
      sda_prev_q <= sync_q[1];
   end

   assign scl_s     = sync_q[0];
   assign sda_s     = sync_q[1];
   assign strap_s   = sync_q[5:2];
   assign guard_n_s = sync_q[6];
   assign start     = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop      = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign scl_rise  = scl_s & ~scl_prev_q;
   assign scl_fall  = ~scl_s & scl_prev_q;

   // ----------------------------------------
   // Decoder state
   // ----------------------------------------
   wdd_state_type state_q, state_d;
   logic [3:0]    cnt_q, cnt_d;
   logic [7:0]    shift_q, shift_d;
   logic [7:0]    tx_q, tx_d;
   logic          oe_q, oe_d;
   logic          pot_q, pot_d;
   logic [1:0]    slot_q, slot_d;
   logic          pend_q, pend_d;
   logic          gang_q, gang_d;
   logic [5:0]    pval_q, pval_d;
   logic          busy_q, busy_d;
   logic [16:0]   prog_q, prog_d;
   logic [5:0]    wiper_q [2];
   logic [5:0]    wiper_d [2];
   logic [5:0]    stored_q [2][4];
   logic [5:0]    stored_d [2][4];
   logic [3:0]    op;
   logic [1:0]    sel;
   logic          pb;
   logic          fmt_ok;

   assign op     = shift_q[wdd_pkg::OP_MSB:wdd_pkg::OP_LSB];
   assign sel    = {shift_q[wdd_pkg::SEL_HI_POS], shift_q[wdd_pkg::SEL_LO_POS]};
   assign pb     = shift_q[wdd_pkg::POT_POS];
   assign fmt_ok = ~shift_q[wdd_pkg::ZERO_POS];

   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      shift_d  = shift_q;
      tx_d     = tx_q;
      oe_d     = oe_q;
      pot_d    = pot_q;
      slot_d   = slot_q;
      pend_d   = pend_q;
      gang_d   = gang_q;
      pval_d   = pval_q;
      busy_d   = busy_q;
      prog_d   = prog_q;
      wiper_d  = wiper_q;
      stored_d = stored_q;
      if (busy_q) begin
         prog_d = prog_q - 17'h1;
         if (prog_q <= 17'h1) begin
            busy_d = 1'b0;
         end
      end
      if (start) begin
         state_d = ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
         pend_d  = 1'b0;
      end else if (stop) begin
         state_d = IDLE;
         oe_d    = 1'b0;
         pend_d  = 1'b0;
         // Guard sampled again here so a late drop still blocks programming
         if (pend_q && guard_n_s) begin
            if (gang_q) begin
               stored_d[0][slot_q] = wiper_q[0];
               stored_d[1][slot_q] = wiper_q[1];
            end else begin
               stored_d[pot_q][slot_q] = pval_q;
            end
            busy_d = 1'b1;
            prog_d = PROG_CYCLES;
         end
      end else if (scl_rise) begin
         unique case (state_q)
            IDLE, WAIT_STOP: begin
            end
            STEP: begin
               if (cnt_q == 4'h0) begin
                  if (sda_s) begin
                     if (wiper_q[pot_q] != wdd_pkg::TAP_MAX) begin
                        wiper_d[pot_q] = wiper_q[pot_q] + 6'h1;
                     end
                  end else if (wiper_q[pot_q] != wdd_pkg::TAP_MIN) begin
                     wiper_d[pot_q] = wiper_q[pot_q] - 6'h1;
                  end
               end else begin
                  cnt_d = cnt_q + 4'h1;
               end
            end
            TX: begin
               cnt_d = cnt_q + 4'h1;
               // Master did not acknowledge: stop sending
               if (cnt_q == wdd_pkg::BIT_ACK && sda_s) begin
                  state_d = WAIT_STOP;
               end
            end
            default: begin
               cnt_d = cnt_q + 4'h1;
               if (cnt_q < wdd_pkg::BIT_ACK) begin
                  shift_d = {shift_q[6:0], sda_s};
               end
            end
         endcase
      end else if (scl_fall && state_q != IDLE) begin
         if (cnt_q == wdd_pkg::BIT_DONE) begin
            cnt_d = 4'h0;
            oe_d  = (state_q == TX) ? ~tx_q[7] : 1'b0;
         end else if (cnt_q == wdd_pkg::BIT_ACK) begin
            oe_d = 1'b0;
            unique case (state_q)
               ADDR: begin
                  state_d = IDLE;
                  if (shift_q[7:4] == wdd_pkg::TYPE_ID && shift_q[3:0] == strap_s
                      && !busy_q) begin
                     oe_d    = 1'b1;
                     state_d = INSTR;
                  end
               end
               INSTR: begin
                  oe_d    = 1'b1;
                  state_d = WAIT_STOP;
                  pot_d   = pb;
                  slot_d  = sel;
                  case (op)
                     wdd_pkg::OP_RD_WIPER: begin
                        if (sel == 2'h0 && fmt_ok) begin
                           tx_d    = {2'h0, wiper_q[pb]};
                           state_d = TX;
                        end
                     end
                     wdd_pkg::OP_WR_WIPER: begin
                        if (sel == 2'h0 && fmt_ok) begin
                           state_d = RX_WIPER;
                        end
                     end
                     wdd_pkg::OP_RD_STORED: begin
                        if (fmt_ok) begin
                           tx_d    = {2'h0, stored_q[pb][sel]};
                           state_d = TX;
                        end
                     end
                     wdd_pkg::OP_WR_STORED: begin
                        if (fmt_ok) begin
                           state_d = RX_STORED;
                        end
                     end
                     wdd_pkg::OP_TO_WIPER: begin
                        if (fmt_ok) begin
                           wiper_d[pb] = stored_q[pb][sel];
                        end
                     end
                     wdd_pkg::OP_TO_STORED: begin
                        if (fmt_ok) begin
                           oe_d   = guard_n_s;
                           pend_d = guard_n_s;
                           gang_d = 1'b0;
                           pval_d = wiper_q[pb];
                        end
                     end
                     wdd_pkg::OP_GANG_WIPER: begin
                        if (fmt_ok && !pb) begin
                           wiper_d[0] = stored_q[0][sel];
                           wiper_d[1] = stored_q[1][sel];
                        end
                     end
                     wdd_pkg::OP_GANG_STORE: begin
                        if (fmt_ok && !pb) begin
                           oe_d   = guard_n_s;
                           pend_d = guard_n_s;
                           gang_d = 1'b1;
                        end
                     end
                     wdd_pkg::OP_STEP: begin
                        if (sel == 2'h0 && fmt_ok) begin
                           state_d = STEP;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
               RX_WIPER: begin
                  oe_d           = 1'b1;
                  wiper_d[pot_q] = shift_q[5:0];
                  state_d        = WAIT_STOP;
               end
               RX_STORED: begin
                  oe_d    = guard_n_s;
                  pend_d  = guard_n_s;
                  gang_d  = 1'b0;
                  pval_d  = shift_q[5:0];
                  state_d = WAIT_STOP;
               end
               default: begin
               end
            endcase
         end else if (state_q == TX) begin
            oe_d = ~tx_q[3'(3'h7 - cnt_q[2:0])];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         oe_q    <= 1'b0;
         pot_q   <= 1'b0;
         slot_q  <= 2'h0;
         pend_q  <= 1'b0;
         gang_q  <= 1'b0;
         pval_q  <= 6'h00;
         busy_q  <= 1'b0;
         prog_q  <= 17'h0;
         for (int p = 0; p < 2; p++) begin
            wiper_q[p] <= stored_q[p][0];
            for (int s = 0; s < 4; s++) begin
               stored_q[p][s] <= wdd_pkg::STORED_RESET;
            end
         end
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         shift_q  <= shift_d;
         tx_q     <= tx_d;
         oe_q     <= oe_d;
         pot_q    <= pot_d;
         slot_q   <= slot_d;
         pend_q   <= pend_d;
         gang_q   <= gang_d;
         pval_q   <= pval_d;
         busy_q   <= busy_d;
         prog_q   <= prog_d;
         wiper_q  <= wiper_d;
         stored_q <= stored_d;
      end
   end

   // ----------------------------------------
   // Tap decode
   // ----------------------------------------
   logic [63:0] tap_d [2];
   logic [63:0] tap_q [2];

   for (genvar p = 0; p < 2; p++) begin : g_pot
      for (genvar i = 0; i < wdd_pkg::N_TAPS; i++) begin : g_tap
         assign tap_d[p][i] = (wiper_d[p] == 6'(i));
      end
   end

   always_ff @(posedge clock) begin
      tap_q <= tap_d;
   end

   assign sda_out    = 1'b0;
   assign sda_oe     = oe_q;
   assign wiper_pos0 = wiper_q[0];
   assign wiper_pos1 = wiper_q[1];
   assign tap_sel0   = tap_q[0];
   assign tap_sel1   = tap_q[1];
   assign busy       = busy_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_onehot;
      $onehot(tap_q[0]) && tap_q[0][wiper_q[0]];
   endproperty
   a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

   property p_reset_load;
      $past(rst) |-> wiper_q[0] == stored_q[0][0];
   endproperty
   a_reset_load: assert property (p_reset_load) else $error("wiper not loaded");

   property p_busy_nack;
      busy_q && state_q == ADDR && scl_fall && cnt_q == wdd_pkg::BIT_ACK |=> !oe_q;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

   property p_step_up;
      state_q == STEP && !pot_q && cnt_q == 4'h0 && scl_rise && !start && !stop
      && sda_s && wiper_q[0] != wdd_pkg::TAP_MAX |=> wiper_q[0] == $past(wiper_q[0]) + 6'h1;
   endproperty
   a_step_up: assert property (p_step_up) else $error("no step up");

   property p_step_dn;
      state_q == STEP && !pot_q && cnt_q == 4'h0 && scl_rise && !start && !stop
      && !sda_s && wiper_q[0] != wdd_pkg::TAP_MIN |=> wiper_q[0] == $past(wiper_q[0]) - 6'h1;
   endproperty
   a_step_dn: assert property (p_step_dn) else $error("no step down");

   property p_sat;
      state_q == STEP && !pot_q && scl_rise && sda_s && wiper_q[0] == wdd_pkg::TAP_MAX
      |=> wiper_q[0] == wdd_pkg::TAP_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("step passed top tap");

   property p_guard;
      state_q == RX_STORED && scl_fall && cnt_q == wdd_pkg::BIT_ACK && !start && !stop
      && !guard_n_s |=> !oe_q && !pend_q;
   endproperty
   a_guard: assert property (p_guard) else $error("guarded write acked");

   property p_prog_at_stop;
      $rose(busy_q) |-> $past(stop) && $past(pend_q) && prog_q == PROG_CYCLES;
   endproperty
   a_prog_at_stop: assert property (p_prog_at_stop) else $error("program not at stop");

   property p_nop;
      state_q == INSTR && scl_fall && cnt_q == wdd_pkg::BIT_ACK && !start && !stop
      && op == 4'h0 |=> !pend_q && wiper_q[0] == $past(wiper_q[0]) && state_q == WAIT_STOP;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");

   c_step: cover property (state_q == STEP && scl_rise && cnt_q == 4'h0);
   c_prog: cover property ($rose(busy_q));
   c_read: cover property (state_q == TX && scl_fall && cnt_q == wdd_pkg::BIT_DONE);
endmodule

// File: wdd_pkg.sv
// Constants for the dual wiper instruction decoder.
// Assumes a 25 MHz system clock that oversamples the two-wire bus.
package wdd_pkg;
   // ----------------------------------------
   // Slave address and instruction fields
   // ----------------------------------------
   // Type identifier value is arbitrary
   localparam logic [3:0] TYPE_ID    = 4'ha;
   localparam int         OP_MSB     = 7;
   localparam int         OP_LSB     = 4;
   localparam int         SEL_HI_POS = 3;
   localparam int         SEL_LO_POS = 2;
   localparam int         ZERO_POS   = 1;
   localparam int         POT_POS    = 0;
   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [3:0] OP_RD_WIPER   = 4'h9;
   localparam logic [3:0] OP_WR_WIPER   = 4'ha;
   localparam logic [3:0] OP_RD_STORED  = 4'hb;
   localparam logic [3:0] OP_WR_STORED  = 4'hc;
   localparam logic [3:0] OP_TO_WIPER   = 4'hd;
   localparam logic [3:0] OP_TO_STORED  = 4'he;
   localparam logic [3:0] OP_GANG_WIPER = 4'h1;
   localparam logic [3:0] OP_GANG_STORE = 4'h8;
   localparam logic [3:0] OP_STEP       = 4'h2;
   // ----------------------------------------
   // Widths, reset values and bit counts
   // ----------------------------------------
   localparam int         N_TAPS       = 64;
   localparam logic [5:0] TAP_MAX      = 6'h3f;
   localparam logic [5:0] TAP_MIN      = 6'h00;
   localparam logic [5:0] STORED_RESET = 6'h00;
   localparam logic [3:0] BIT_ACK      = 4'h8;
   localparam logic [3:0] BIT_DONE     = 4'h9;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int PROG_TIME_US = 5000;
   localparam int CLK_KHZ      = 25000;
   localparam int PROG_CYCLES  = PROG_TIME_US * CLK_KHZ / 1000;
   localparam int PROG_W       = 17;
endpackage

// File: wdd_master.sv
// Two-wire bus master model that drives the decoder's serial pins.
// Assumes the bench clock; scl runs only within frames and sda has a pull-up.
`timescale 1ns/1ns
module wdd_master (
   input  wire logic clock,
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda
);
   // ----------------------------------------
   // Bit level: 4 clocks low, 4 clocks high
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic clk_bit(input logic b, output logic s);
      @(posedge clock) scl <= 1'b0;
      @(posedge clock) sda <= b;
      repeat (3) @(posedge clock);
      scl <= 1'b1;
      repeat (3) @(posedge clock);
      s = sda_w;
   endtask

   task automatic start_c();
      @(posedge clock) sda <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic stop_c();
      @(posedge clock) scl <= 1'b0;
      @(posedge clock) sda <= 1'b0;
      repeat (3) @(posedge clock);
      scl <= 1'b1;
      repeat (4) @(posedge clock);
      sda <= 1'b1;
      repeat (6) @(posedge clock);
   endtask

   // ----------------------------------------
   // Byte and frame level
   // ----------------------------------------
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask

   task automatic get_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(last, s);
   endtask

   // Address, instruction, then one data byte or none, then stop
   task automatic xfer(input logic [7:0] adr, input logic [7:0] ins, input int nd, input logic [7:0] wd,
                       output logic [7:0] rd, output logic [2:0] ak);
      rd = 8'h00;
      ak = 3'h0;
      start_c();
      put_byte(adr, ak[0]);
      if (ak[0]) begin
         put_byte(ins, ak[1]);
         if (nd == 1) put_byte(wd, ak[2]);
         if (nd == 2) get_byte(1'b1, rd);
      end
      stop_c();
   endtask
endmodule

// File: wdd_decoder_tb.sv
// Self-checking bench for the dual wiper instruction decoder.
// Assumes the bus master model drives scl and sda; sda is an open-drain wire with pull-up.
`timescale 1ns/1ns
module wdd_decoder_tb;
   localparam int PROG = 200;
   logic        clock, rst, scl, sda, sda_w, sda_out, sda_oe, write_guard_n, busy;
   logic [3:0]  strap;
   logic [5:0]  wiper_pos0, wiper_pos1;
   logic [5:0]  wexp [2];
   logic [5:0]  sexp [2][4];
   logic [63:0] tap_sel0, tap_sel1;
   logic [31:0] seed;
   logic [7:0]  rd;
   logic [2:0]  ak;
   int          err_count, n_tests, busy_cnt;

   assign sda_w = sda & (sda_oe ? sda_out : 1'b1);

   wdd_decoder #(.PROG_CYCLES(17'(PROG))) wdd_decoder_i (
      .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_3(strap[3]), .addr_strap_2(strap[2]), .addr_strap_1(strap[1]),
      .addr_strap_0(strap[0]), .write_guard_n(write_guard_n), .wiper_pos0(wiper_pos0),
      .wiper_pos1(wiper_pos1), .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .busy(busy));

   wdd_master wdd_master_i (.clock(clock), .sda_w(sda_w), .scl(scl), .sda(sda));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) if (busy === 1'b1) busy_cnt <= busy_cnt + 1;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] rnd6();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[5:0];
   endfunction

   function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] sel, input logic p);
      return {op, sel, 1'b0, p};
   endfunction

   task automatic complete_run();
      $display("Checks %0d, errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %0t %s", $time, msg);
         err_count++;
      end
   endtask

   task automatic chk_w();
      chk(64'(wiper_pos0), 64'(wexp[0]), "wiper 0");
      chk(64'(wiper_pos1), 64'(wexp[1]), "wiper 1");
      chk(tap_sel0, 64'h1 << wexp[0], "tap 0");
      chk(tap_sel1, 64'h1 << wexp[1], "tap 1");
   endtask

   task automatic cmd(input logic [7:0] i, input int nd, input logic [5:0] wd);
      wdd_master_i.xfer({wdd_pkg::TYPE_ID, strap}, i, nd, {2'b00, wd}, rd, ak);
   endtask

   task automatic rd_chk(input logic p, input logic [1:0] s);
      cmd(ins(wdd_pkg::OP_RD_STORED, s, p), 2, 6'h00);
      chk(64'(rd), 64'(sexp[p][s]), "stored read");
   endtask

   // Poll with the address until the programming cycle ends
   task automatic wait_prog();
      logic a;
      int   n;
      a = 1'b0;
      n = 0;
      chk(64'(busy), 64'h1, "busy after stop");
      while (!a && n < 20) begin
         wdd_master_i.start_c();
         wdd_master_i.put_byte({wdd_pkg::TYPE_ID, strap}, a);
         wdd_master_i.stop_c();
         if (n == 0) chk(64'(a), 64'h0, "ack while busy");
         n++;
      end
      chk(64'(a), 64'h1, "poll bound used up");
      chk(64'(busy_cnt > 0 && busy_cnt <= PROG), 64'h1, "program time");
      busy_cnt = 0;
      if (!a) complete_run();
   endtask

   task automatic step(input logic p, input logic [5:0] v, input logic up, input logic [5:0] e);
      logic a;
      cmd(ins(wdd_pkg::OP_WR_WIPER, 2'h0, p), 1, v);
      wdd_master_i.start_c();
      wdd_master_i.put_byte({wdd_pkg::TYPE_ID, strap}, a);
      wdd_master_i.put_byte(ins(wdd_pkg::OP_STEP, 2'h0, p), a);
      repeat (3) wdd_master_i.clk_bit(up, a);
      repeat (6) @(posedge clock);
      wexp[p] = e;
      chk_w();
      wdd_master_i.stop_c();
      wexp[p] = (e == 6'h00) ? 6'h00 : e - 6'h01;
      chk_w();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      seed = 32'h9bc69c95;
      write_guard_n = 1'b1;
      strap = 4'h0;
      err_count = 0;
      n_tests = 0;
      busy_cnt = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      strap <= 4'(rnd6());
      repeat (6) @(posedge clock);
      wexp = '{6'h00, 6'h00};
      foreach (sexp[p, s]) sexp[p][s] = 6'h00;
      chk_w();
      chk(64'(busy), 64'h0, "busy after reset");
      for (int p = 0; p < 2; p++) begin
         wexp[p] = rnd6();
         cmd(ins(wdd_pkg::OP_WR_WIPER, 2'h0, p[0]), 1, wexp[p]);
         chk(64'(ak), 64'h7, "write acks");
         chk_w();
         cmd(ins(wdd_pkg::OP_RD_WIPER, 2'h0, p[0]), 2, 6'h00);
         chk(64'(rd), 64'(wexp[p]), "wiper read");
      end
      foreach (sexp[p, s]) begin
         sexp[p][s] = rnd6();
         cmd(ins(wdd_pkg::OP_WR_STORED, s[1:0], p[0]), 1, sexp[p][s]);
         wait_prog();
      end
      foreach (sexp[p, s]) rd_chk(p[0], s[1:0]);
      cmd(ins(wdd_pkg::OP_TO_WIPER, 2'h2, 1'b0), 0, 6'h00);
      wexp[0] = sexp[0][2];
      chk(64'(ak), 64'h3, "two-byte acks");
      chk_w();
      cmd(ins(wdd_pkg::OP_TO_STORED, 2'h3, 1'b1), 0, 6'h00);
      sexp[1][3] = wexp[1];
      wait_prog();
      rd_chk(1'b1, 2'h3);
      cmd(ins(wdd_pkg::OP_GANG_WIPER, 2'h1, 1'b0), 0, 6'h00);
      wexp = '{sexp[0][1], sexp[1][1]};
      chk_w();
      cmd(ins(wdd_pkg::OP_GANG_STORE, 2'h0, 1'b0), 0, 6'h00);
      sexp[0][0] = wexp[0];
      sexp[1][0] = wexp[1];
      wait_prog();
      rd_chk(1'b0, 2'h0);
      rd_chk(1'b1, 2'h0);
      step(1'b0, 6'h3e, 1'b1, 6'h3f);
      step(1'b1, 6'h01, 1'b0, 6'h00);
      write_guard_n <= 1'b0;
      repeat (4) @(posedge clock);
      cmd(ins(wdd_pkg::OP_WR_STORED, 2'h1, 1'b0), 1, ~sexp[0][1]);
      chk(64'(ak), 64'h3, "guarded data ack");
      chk(64'(busy), 64'h0, "guarded busy");
      rd_chk(1'b0, 2'h1);
      wexp[0] = rnd6();
      cmd(ins(wdd_pkg::OP_WR_WIPER, 2'h0, 1'b0), 1, wexp[0]);
      chk_w();
      write_guard_n <= 1'b1;
      wdd_master_i.xfer({~wdd_pkg::TYPE_ID, strap}, ins(wdd_pkg::OP_WR_WIPER, 2'h0, 1'b0), 1, 8'h15, rd, ak);
      chk(64'(ak[0]), 64'h0, "bad type ack");
      wdd_master_i.xfer({wdd_pkg::TYPE_ID, ~strap}, ins(wdd_pkg::OP_WR_WIPER, 2'h0, 1'b0), 1, 8'h15, rd, ak);
      chk(64'(ak[0]), 64'h0, "bad strap ack");
      chk_w();
      foreach (wexp[p]) begin
         for (int o = 0; o < 16; o++) begin
            if (o inside {0, 3, 4, 5, 6, 7, 15}) begin
               cmd(ins(4'(o), 2'(rnd6()), p[0]), 0, 6'h00);
               chk(64'(ak), 64'h3, "unknown opcode ack");
            end
         end
      end
      chk_w();
      chk(64'(busy_cnt), 64'h0, "unknown opcode programmed");
      complete_run();
   end

   initial begin
      repeat (100000) @(posedge clock);
      err_count++;
      complete_run();
   end
endmodule
